// [verilog/slab_defines.svh]
// Timing constants for the status and alarm code lamp logic
// Notes on behaviour
// [RULE_01] Green when powered and on, red on alarm
// [RULE_02] Warning flashes status lamp orange one second
// [RULE_03] Overload, regeneration or fan fault raise warning
// [RULE_04] Code lamp dark until an alarm appears
// [RULE_05] Orange flashes for tens, red for units
// [RULE_06] Tens flash one second, units half second
// [RULE_07] Two seconds dark, then repeat while alarmed
`ifndef SLAB_DEFINES_SVH
`define SLAB_DEFINES_SVH
`define SLAB_CLK_HZ        50000000
`define SLAB_TENS_ON_MS    1000
`define SLAB_UNIT_ON_MS    500
`define SLAB_GAP_MS        500
`define SLAB_PAUSE_MS      2000
`define SLAB_WARN_MS       1000
`define SLAB_MS_CYC        (`SLAB_CLK_HZ / 1000)
`endif

// [verilog/slab_pkg.sv]
// Types shared by the lamp logic
package slab_pkg;
  // Lamp colour code: bit 1 red, bit 0 green, both for orange
  typedef enum logic [1:0] {
    SLAB_OFF    = 2'h0,
    SLAB_GREEN  = 2'h1,
    SLAB_RED    = 2'h2,
    SLAB_ORANGE = 2'h3
  } slab_color_e;
  // Code sequencer states, one-hot
  typedef enum logic [5:0] {
    SLAB_IDLE   = 6'h01,
    SLAB_TON    = 6'h02,
    SLAB_TGAP   = 6'h04,
    SLAB_UON    = 6'h08,
    SLAB_UGAP   = 6'h10,
    SLAB_PAUSE  = 6'h20
  } slab_state_e;
endpackage

// [verilog/slab_ms_tick.sv]
// Millisecond tick generator
`timescale 1ns/100ps
`include "slab_defines.svh"
module slab_ms_tick #(
  parameter int CYC_PER_MS = `SLAB_MS_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  output logic      tick
);
  logic [31:0] cnt_r; // Cycle counter within one millisecond

  ////////////////////////////////////////////////////////////////////////////
  // Free running divider; tick lasts one cycle per millisecond
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 32'h0000_0000;
      tick  <= 1'b0;
    end else if (cnt_r == 32'(CYC_PER_MS - 1)) begin
      cnt_r <= 32'h0000_0000;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h0000_0001;
      tick  <= 1'b0;
    end
  end
endmodule

// [verilog/slab_top.sv]
// Status lamp and alarm code lamp driver
`timescale 1ns/100ps
`include "slab_defines.svh"
module slab_top #(
  parameter int CYC_PER_MS = `SLAB_MS_CYC, // Shorten in simulation
  parameter int TENS_MS    = `SLAB_TENS_ON_MS,
  parameter int UNIT_MS    = `SLAB_UNIT_ON_MS,
  parameter int GAP_MS     = `SLAB_GAP_MS,
  parameter int PAUSE_MS   = `SLAB_PAUSE_MS,
  parameter int WARN_MS    = `SLAB_WARN_MS
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       power_on,
  input  wire logic       drive_on,
  input  wire logic       warn_overload,
  input  wire logic       warn_regen,
  input  wire logic       warn_fan,
  input  wire logic       alarm_active,
  input  wire logic [6:0] alarm_code,
  output logic      [1:0] status_led,
  output logic      [1:0] code_led
);
  ////////////////////////////////////////////////////////////////////////////
  // Timebase and warning bookkeeping
  logic        ms_tick;      // One pulse per millisecond
  logic        warn_any;     // Any warning source high
  logic        warn_any_d_r; // Previous warning level, for edge find
  logic [11:0] warn_ms_r;    // Orange time left on status lamp
  // Code sequencer bookkeeping; twelve bits hold phases up to four seconds
  logic [11:0] dur_r;        // Time left in current sequencer phase
  logic [3:0]  tens_r;       // Tens flashes left
  logic [3:0]  units_r;      // Units flashes left
  slab_pkg::slab_state_e st_r; // Current sequencer phase, one-hot

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond timebase shared by the warning timer and the sequencer.
  // One common divider keeps every phase on the same grid; the price is
  // up to one millisecond of slack on the first phase after an event.
  slab_ms_tick #(
    .CYC_PER_MS (CYC_PER_MS)
  ) slab_ms_tick_inst (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .tick    (ms_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Warning detect: a rising edge of the OR of all sources restarts one orange second
  // A source that stays high gives one flash only; a fresh edge, even
  // during an orange second, restarts the full second.
  // The edge wins over the countdown when both fall in one cycle.
  assign warn_any = warn_overload | warn_regen | warn_fan; // RULE_03

  // Edge register and orange countdown
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      warn_any_d_r <= 1'b0;
      warn_ms_r    <= 12'h000;
    end else begin
      warn_any_d_r <= warn_any;
      if (warn_any && !warn_any_d_r) begin
        warn_ms_r <= 12'(WARN_MS); // RULE_02
      end else if (ms_tick && warn_ms_r != 12'h000) begin
        warn_ms_r <= warn_ms_r - 12'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status colour: alarm beats warning beats green; dark when none of these holds
  // Registered so the lamp never glitches between colours; it therefore
  // trails alarm and power by one clock and warnings by two, far below what an eye can see.
  // A warning during an alarm still runs its second, hidden under red.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_led <= slab_pkg::SLAB_OFF;
    end else if (alarm_active) begin
      status_led <= slab_pkg::SLAB_RED; // RULE_01
    end else if (warn_ms_r != 12'h000) begin
      status_led <= slab_pkg::SLAB_ORANGE; // RULE_02
    end else if (power_on && drive_on) begin
      status_led <= slab_pkg::SLAB_GREEN; // RULE_01
    end else begin
      status_led <= slab_pkg::SLAB_OFF;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Code sequencer; each flash is followed by a dark gap so counts are seen
  // Phases: tens flashes with gaps, units flashes with gaps, long pause,
  // then back to idle where the code is taken again. Dropping the alarm
  // sends it to idle at once, whatever phase it is in.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r    <= slab_pkg::SLAB_IDLE;
      dur_r   <= 12'h000;
      tens_r  <= 4'h0;
      units_r <= 4'h0;
    end else if (!alarm_active) begin
      // No alarm: park in idle so the next alarm starts from its tens digit
      st_r <= slab_pkg::SLAB_IDLE; // RULE_04
    end else begin
      case (st_r)
        // Idle: take the code and pick the first phase
        slab_pkg::SLAB_IDLE: begin
          // Code latched here so a changing input cannot garble a sequence
          tens_r  <= 4'(alarm_code / 7'h0a); // RULE_05
          units_r <= 4'(alarm_code % 7'h0a);
          if (alarm_code >= 7'h0a) begin
            // Tens digit present: orange flashes come first
            st_r  <= slab_pkg::SLAB_TON;
            dur_r <= 12'(TENS_MS); // RULE_06
          end else if (alarm_code != 7'h00) begin
            // Single digit: red flashes only
            st_r  <= slab_pkg::SLAB_UON;
            dur_r <= 12'(UNIT_MS);
          end else begin
            // Code zero: nothing to count, the lamp only waits; entering
            // the red phase here would wrap the units counter
            st_r  <= slab_pkg::SLAB_PAUSE;
            dur_r <= 12'(PAUSE_MS); // RULE_07
          end
        end
        // Tens flash: orange for TENS_MS, one tens count used at its end
        slab_pkg::SLAB_TON: begin
          if (ms_tick) begin
            if (dur_r == 12'h001) begin
              st_r   <= slab_pkg::SLAB_TGAP;
              dur_r  <= 12'(GAP_MS);
              tens_r <= tens_r - 4'h1;
            end else begin
              dur_r <= dur_r - 12'h001;
            end
          end
        end
        // Gap after a tens flash: dark, then more tens, the units, or the
        // pause when the units digit is zero
        // The counts were taken in idle, so nothing here reads the input
        slab_pkg::SLAB_TGAP: begin
          if (ms_tick) begin
            if (dur_r != 12'h001) begin
              dur_r <= dur_r - 12'h001;
            end else if (tens_r != 4'h0) begin
              st_r  <= slab_pkg::SLAB_TON;
              dur_r <= 12'(TENS_MS);
            end else if (units_r != 4'h0) begin
              st_r  <= slab_pkg::SLAB_UON; // RULE_05
              dur_r <= 12'(UNIT_MS);
            end else begin
              st_r  <= slab_pkg::SLAB_PAUSE;
              dur_r <= 12'(PAUSE_MS);
            end
          end
        end
        // Units flash: red for UNIT_MS, one units count used at its end
        // Shorter than a tens flash so the two digits read apart
        slab_pkg::SLAB_UON: begin
          if (ms_tick) begin
            if (dur_r == 12'h001) begin
              st_r    <= slab_pkg::SLAB_UGAP;
              dur_r   <= 12'(GAP_MS);
              units_r <= units_r - 4'h1;
            end else begin
              dur_r <= dur_r - 12'h001;
            end
          end
        end
        // Gap after a units flash: dark, then the next red flash or the
        // long pause once the last units flash is done
        // The gap and the pause together mark the end of the code
        slab_pkg::SLAB_UGAP: begin
          if (ms_tick) begin
            if (dur_r != 12'h001) begin
              dur_r <= dur_r - 12'h001;
            end else if (units_r != 4'h0) begin
              st_r  <= slab_pkg::SLAB_UON;
              dur_r <= 12'(UNIT_MS); // RULE_06
            end else begin
              st_r  <= slab_pkg::SLAB_PAUSE; // RULE_07
              dur_r <= 12'(PAUSE_MS);
            end
          end
        end
        // Long pause: dark, then idle, which takes the code afresh so a
        // changed alarm number shows from the next round on
        // Idle costs one extra clock of dark, which no eye can notice
        slab_pkg::SLAB_PAUSE: begin
          if (ms_tick) begin
            if (dur_r == 12'h001) begin
              st_r <= slab_pkg::SLAB_IDLE; // RULE_07
            end else begin
              dur_r <= dur_r - 12'h001;
            end
          end
        end
        // Unreachable codes fall back to idle, so a struck state bit
        // heals within one clock instead of locking the lamp
        default: begin
          st_r <= slab_pkg::SLAB_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Code lamp colour registered from the sequencer state
  // The alarm term here turns the lamp dark on the same clock as the
  // sequencer returns to idle, so no stale flash survives an alarm drop.
  // Gaps, pause and idle all show dark; only the two flash phases light.
  // Green never appears on this lamp.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      code_led <= slab_pkg::SLAB_OFF;
    end else if (alarm_active && st_r == slab_pkg::SLAB_TON) begin
      code_led <= slab_pkg::SLAB_ORANGE; // RULE_05
    end else if (alarm_active && st_r == slab_pkg::SLAB_UON) begin
      code_led <= slab_pkg::SLAB_RED; // RULE_05
    end else begin
      code_led <= slab_pkg::SLAB_OFF; // RULE_04
    end
  end
endmodule

// [verif/slab_top_monitor.sv]
// Checker for the status and code lamp driver
`timescale 1ns/100ps
module slab_mon (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       power_on,
  input wire logic       drive_on,
  input wire logic       warn_overload,
  input wire logic       warn_regen,
  input wire logic       warn_fan,
  input wire logic       alarm_active,
  input wire logic [6:0] alarm_code,
  input wire logic [1:0] status_led,
  input wire logic [1:0] code_led
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire logic warn_any = warn_overload | warn_regen | warn_fan;
  ////////////////////////////////////////////////////////////////
  red_status_a: assert property (alarm_active |=> status_led == 2'h2)
    else $error("status lamp not red on alarm");
  green_gate_a: assert property (status_led == 2'h1 |-> $past(power_on && drive_on))
    else $error("green without power and drive");
  warn_start_a: assert property ($rose(warn_any) ##0 (!alarm_active)[*3] |-> status_led == 2'h3)
    else $error("warning did not light orange");
  warn_hold_a: assert property ($rose(status_led == 2'h3) |-> (status_led != 2'h1)[*8])
    else $error("orange flash cut short");
  code_dark_a: assert property (!alarm_active |=> code_led == 2'h0)
    else $error("code lamp lit without alarm");
  no_green_a: assert property (code_led != 2'h1)
    else $error("code lamp showed green");
  flash_gap_a: assert property ($fell(code_led[1]) |-> code_led == 2'h0)
    else $error("no dark gap after a flash");
  // Main scenarios reached
  cover property (status_led == 2'h3);
  cover property (code_led == 2'h3);
  cover property (code_led == 2'h2);
endmodule
bind slab_top slab_mon slab_mon_inst (.clk_sys(clk_sys), .rst_n(rst_n), .power_on(power_on),
  .drive_on(drive_on), .warn_overload(warn_overload), .warn_regen(warn_regen),
  .warn_fan(warn_fan), .alarm_active(alarm_active), .alarm_code(alarm_code),
  .status_led(status_led), .code_led(code_led));

// [verif/slab_top_tb.sv]
// Self-checking bench for the lamp driver
`timescale 1ns/100ps
module slab_top_tb;
  localparam int M = 4; // Cycles per ms tick, shortened so the run stays short
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic       pwr = 1'b0;
  logic       drv = 1'b0;
  logic [2:0] warn = 3'h0;
  logic       alarm = 1'b0;
  logic [6:0] acode = 7'h00;
  logic [1:0] status_led;
  logic [1:0] code_led;
  int         err_count = 0;
  int         total_checks = 0;
  always #10 clk_sys = ~clk_sys;
  slab_top #(.CYC_PER_MS(M), .TENS_MS(10), .UNIT_MS(5), .GAP_MS(5), .PAUSE_MS(20),
    .WARN_MS(10)) slab_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .power_on(pwr),
    .drive_on(drv), .warn_overload(warn[0]), .warn_regen(warn[1]), .warn_fan(warn[2]),
    .alarm_active(alarm), .alarm_code(acode), .status_led(status_led), .code_led(code_led));
  ////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input bit ok, input string msg);
    total_checks++;
    if (!ok) begin
      err_count++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Length of the current code lamp run; bounded so a stuck lamp ends the run
  task automatic seg(output logic [1:0] c, output int n);
    c = code_led;
    n = 0;
    while (code_led === c && n < 500) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 500) begin
      chk(1'b0, "code lamp stuck");
      final_report();
    end
  endtask
  // Counts the flashes of one code sequence, from dark to the long pause
  task automatic count_code(output int ora, output int red, output int n);
    logic [1:0] c;
    ora = 0;
    red = 0;
    seg(c, n);
    for (int k = 0; k < 10 && !(c === 2'h0 && n > 60); k++) begin
      seg(c, n);
      if (c === 2'h3) begin
        ora++;
        chk(n >= 9 * M && n <= 11 * M, "tens length");
      end
      if (c === 2'h2) begin
        red++;
        chk(n >= 4 * M && n <= 6 * M, "units length");
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_status();
    pwr <= 1'b1;
    drv <= 1'b1;
    wt(3);
    chk(status_led === 2'h1, "not green");
    drv <= 1'b0;
    wt(3);
    chk(status_led === 2'h0, "lit while off");
    drv <= 1'b1;
    wt(3);
    chk(status_led === 2'h1, "not green again");
    pwr <= 1'b0;
    wt(3);
    chk(status_led === 2'h0, "lit without power");
    pwr <= 1'b1;
    wt(3);
    $display("status test done");
  endtask
  // Each source alone must give one orange second
  task automatic t_warn();
    for (int i = 0; i < 3; i++) begin
      warn[i] <= 1'b1;
      wt(4);
      warn[i] <= 1'b0;
      chk(status_led === 2'h3, "no orange");
      wt(9 * M - 4);
      chk(status_led === 2'h3, "orange short");
      wt(3 * M + 4);
      chk(status_led === 2'h1, "orange long");
    end
    $display("warning test done");
  endtask
  // Code 21: two orange, one red, long pause, then repeat
  task automatic t_code();
    int n;
    int ora;
    int red;
    acode <= 7'h15;
    wt(5);
    chk(code_led === 2'h0, "code lamp lit");
    alarm <= 1'b1;
    wt(2);
    chk(status_led === 2'h2, "status not red");
    count_code(ora, red, n);
    chk(ora == 2 && red == 1, "flash count");
    chk(n >= 24 * M && n <= 26 * M + 4, "pause length");
    chk(code_led === 2'h3, "no repeat");
    // Drop the alarm in mid flash: the lamp must go dark at once
    wt(4);
    alarm <= 1'b0;
    wt(2);
    chk(code_led === 2'h0, "lamp after clear");
    chk(status_led === 2'h1, "status after clear");
    $display("code test done");
  endtask
  // Code 10 gives orange only, code 3 red only, code 0 a dark lamp
  task automatic t_digits();
    int n;
    int ora;
    int red;
    acode <= 7'h0a;
    alarm <= 1'b1;
    count_code(ora, red, n);
    chk(ora == 1 && red == 0, "code ten count");
    chk(n >= 24 * M && n <= 26 * M + 4, "code ten pause");
    alarm <= 1'b0;
    acode <= 7'h03;
    wt(2);
    alarm <= 1'b1;
    count_code(ora, red, n);
    chk(ora == 0 && red == 3, "code three count");
    alarm <= 1'b0;
    acode <= 7'h00;
    wt(2);
    alarm <= 1'b1;
    n = 0;
    repeat (40 * M) begin
      @(posedge clk_sys);
      if (code_led !== 2'h0) begin
        n++;
      end
    end
    chk(n == 0, "code zero lit");
    chk(status_led === 2'h2, "code zero status");
    alarm <= 1'b0;
    wt(2);
    $display("digit test done");
  endtask
  initial begin
    wt(12);
    rst_n <= 1'b1;
    t_status();
    t_warn();
    t_code();
    t_digits();
    final_report();
  end
endmodule
